/* File: core/taeil_pkg.sv */
// Shared constants and carrier types for the trap and edge interrupt logic.
// Assumes a single 250 MHz core clock and an active-low asynchronous reset.
package taeil_pkg;

    // Opcode of the trap instruction; undefined program memory reads as it.
    localparam logic [7:0]  TRAP_OPCODE    = 8'h00;
    // Data returned for an undefined program memory location.
    localparam logic [7:0]  UNDEF_ROM_DATA = 8'h00;
    // Stack pointer value loaded by reset.
    localparam logic [7:0]  SP_RESET       = 8'h2f;
    // Highest address the stack may be popped to.
    localparam logic [7:0]  SP_LIMIT       = 8'h6f;
    // Undefined RAM window and the value it reads back.
    localparam logic [7:0]  UNDEF_RAM_LO   = 8'h30;
    localparam logic [7:0]  UNDEF_RAM_HI   = 8'h3f;
    localparam logic [7:0]  UNDEF_RAM_DATA = 8'hff;
    // Program counter forced after a stack underflow.
    localparam logic [14:0] PC_UNDERFLOW   = 15'h7fff;
    // Low bytes produced by vector arbitration.
    localparam logic [7:0]  VEC_TRAP       = 8'hfe;
    localparam logic [7:0]  VEC_WAKE       = 8'he2;
    localparam logic [7:0]  VEC_DEFAULT    = 8'he0;
    // Number of wakeup port pins.
    localparam int          WAKE_PINS      = 8;

    // Wakeup port configuration as written by software.
    typedef struct packed {
        logic                 groupEn;  // Group interrupt enable.
        logic [WAKE_PINS-1:0] edgeSel;  // One selects the falling edge.
        logic [WAKE_PINS-1:0] enable;   // Per-pin interrupt enable.
    } taeil_wake_cfg_t;

    // Instruction sequencer events, each a one-cycle pulse.
    typedef struct packed {
        logic        instrLoad;   // Instruction register loaded.
        logic [7:0]  opcode;      // Opcode being loaded.
        logic [14:0] instrAddr;   // Address the opcode was fetched from.
        logic        clearTrap;   // Clear-pending instruction executed.
        logic        vector_dispatch_instr;         // Vector dispatch instruction executed.
        logic        irqAck;      // Maskable interrupt taken.
        logic        retIrq;      // Return from interrupt executed.
        logic        push;        // One byte pushed on the stack.
        logic        pop;         // One byte popped from the stack.
    } taeil_seq_evt_t;

endpackage : taeil_pkg

/* File: core/taeil_trap_edge_irq.sv */
// Trap pending flag, illegal execution detection and wakeup port edge
// interrupts for an 8-bit core. Assumes every input is synchronous to
// core_clk and that the sequencer presents events as one-cycle pulses.
//
// Contract
// R1: Trap pending flag is internal, unmapped.
// R2: Chip reset clears the trap pending flag.
// R3: Trap condition sets the pending flag.
// R4: Only clear instruction or reset clears flag.
// R5: Loading opcode 00 raises a software trap.
// R6: Undefined program memory reads as zero.
// R7: Pop beyond 06F forces PC to 7FFF.
// R8: Stack pointer resets to 02F, grows down.
// R9: Undefined RAM 030 to 03F reads ones.
// R10: Trap leaves global enable alone, blocks others.
// R11: Only another trap interrupts a trap routine.
// R12: Trap return address is the trap instruction.
// R13: Trap acknowledged immediately, highest priority.
// R14: Maskable routines are not preempted by maskables.
// R15: Eight edge inputs share one vector.
// R16: Per-pin enable for wakeup interrupts.
// R17: Per-pin rising or falling edge select.
// R18: Pending bits latch edges, act as group flag.
// R19: Needs group enable and global enable.
// R20: Wakeup resumes or services per enable.
// R21: Nested traps keep the flag set once.
// R22: No pending request selects default vector.
module taeil_trap_edge_irq #(
    parameter int PINS = taeil_pkg::WAKE_PINS  // Wakeup port width.
) (
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    input  wire taeil_pkg::taeil_seq_evt_t seqEvt,
    input  wire taeil_pkg::taeil_wake_cfg_t wakeCfg,
    input  wire logic                      globalIrqEnable,
    input  wire logic                      extIrqReq,
    input  wire logic [7:0]                extIrqVec,
    input  wire logic                      lowPowerMode,
    input  wire logic [PINS-1:0]           wakePins,
    input  wire logic [PINS-1:0]           wakePendClear,
    input  wire logic                      progDefined,
    input  wire logic [7:0]                progRawData,
    input  wire logic [7:0]                ramAddr,
    input  wire logic [7:0]                ramRawData,
    output logic                           trapTakeReg,
    output logic [14:0]                    trapReturnAddrReg,
    output logic                           trapPendingReg,
    output logic                           irqReqReg,
    output logic [7:0]                     vectorLowReg,
    output logic [7:0]                     progDataReg,
    output logic [7:0]                     ramDataReg,
    output logic [7:0]                     stackPtrReg,
    output logic                           pcForceReg,
    output logic [14:0]                    pcForceAddrReg,
    output logic [PINS-1:0]                wakePendingReg,
    output logic                           wakeupReg,
    output logic                           wakeServiceReg
);

    // Trap group state and next values.
    logic        trapPendNext;      // Next trap pending flag.
    logic        trapTakeNext;      // Next trap acknowledge pulse.
    logic [14:0] trapRetNext;       // Next return address.
    logic        trapLoad;          // Trap opcode loaded this cycle.

    // Memory return group.
    logic [7:0]  progDataNext;      // Next program data.
    logic [7:0]  ramDataNext;       // Next RAM data.
    logic        ramUndef;          // Address falls in undefined RAM.

    // Stack group.
    logic [7:0]  spNext;            // Next stack pointer.
    logic        pcForceNext;       // Next underflow redirect pulse.
    logic [14:0] pcForceAddrNext;   // Next redirect address.
    logic        underflow;         // Pop past the stack limit.

    // Wakeup port group.
    logic [PINS-1:0] pinsPrevReg;   // Pin levels one cycle ago.
    logic            primedReg;     // Previous levels are valid.
    logic [PINS-1:0] edgeEvt;       // Selected edge seen per pin.
    logic [PINS-1:0] wakePendNext;  // Next pending bits.
    logic            wakeupNext;    // Next wakeup pulse.
    logic            wakeServNext;  // Next service-first flag.
    logic            wakeActive;    // Enabled group request present.

    // Interrupt request group.
    logic            inIsrReg;      // A maskable routine is running.
    logic            inIsrNext;     // Next in-routine state.
    logic            irqReqNext;    // Next maskable request.
    logic [7:0]      vectorNext;    // Next vector low byte.

    // The flag lives only here; nothing software addresses can see it.
    // The clear loses against a trap in the same cycle, so a trap is never
    // dropped, and repeated traps leave a single flag to clear.
    always_comb begin
        trapLoad     = seqEvt.instrLoad &&
                       (seqEvt.opcode == taeil_pkg::TRAP_OPCODE); // see R5
        trapPendNext = trapPendingReg;
        trapTakeNext = 1'b0;
        trapRetNext  = trapReturnAddrReg;
        if (trapLoad) begin
            trapPendNext = 1'b1;                // see R3, R21, R1
            trapTakeNext = 1'b1;                // see R13, R11
            trapRetNext  = seqEvt.instrAddr;    // see R12
        end else if (seqEvt.clearTrap) begin
            trapPendNext = 1'b0;                // see R4
        end
    end

    // Trap registers; reset clears the pending flag.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            trapPendingReg    <= 1'b0;          // see R2
            trapTakeReg       <= 1'b0;
            trapReturnAddrReg <= 15'h0000;
        end else begin
            trapPendingReg    <= trapPendNext;
            trapTakeReg       <= trapTakeNext;
            trapReturnAddrReg <= trapRetNext;
        end
    end

    // Undefined program memory yields the trap opcode, and undefined RAM
    // yields ones so an underflowed return lands at the top of memory.
    always_comb begin
        ramUndef     = (ramAddr >= taeil_pkg::UNDEF_RAM_LO) &&
                       (ramAddr <= taeil_pkg::UNDEF_RAM_HI);
        progDataNext = progDefined ? progRawData
                                   : taeil_pkg::UNDEF_ROM_DATA; // see R6
        ramDataNext  = ramUndef ? taeil_pkg::UNDEF_RAM_DATA
                                : ramRawData;                   // see R9
    end

    // Read data registers.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            progDataReg <= 8'h00;
            ramDataReg  <= 8'h00;
        end else begin
            progDataReg <= progDataNext;
            ramDataReg  <= ramDataNext;
        end
    end

    // Stack pointer grows down on push, up on pop. A pop past the limit
    // redirects the PC; the pointer still moves so software sees the damage.
    always_comb begin
        underflow       = seqEvt.pop && (stackPtrReg >= taeil_pkg::SP_LIMIT);
        spNext          = stackPtrReg;
        pcForceNext     = 1'b0;
        pcForceAddrNext = pcForceAddrReg;
        if (seqEvt.push && !seqEvt.pop) begin
            spNext = stackPtrReg - 8'h01;               // see R8
        end else if (seqEvt.pop && !seqEvt.push) begin
            spNext = stackPtrReg + 8'h01;               // see R8
        end
        if (underflow) begin
            pcForceNext     = 1'b1;                     // see R7
            pcForceAddrNext = taeil_pkg::PC_UNDERFLOW;  // see R7
        end
    end

    // Stack registers.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stackPtrReg    <= taeil_pkg::SP_RESET;      // see R8
            pcForceReg     <= 1'b0;
            pcForceAddrReg <= 15'h0000;
        end else begin
            stackPtrReg    <= spNext;
            pcForceReg     <= pcForceNext;
            pcForceAddrReg <= pcForceAddrNext;
        end
    end

    // Edge detection runs one loop per pin. Pending bits latch edges even
    // when the pin is disabled; the enable only gates the request and the wakeup, which
    // matches how software polls the pending register.
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        always_comb begin
            edgeEvt[i] = primedReg && (wakeCfg.edgeSel[i]
                ? (pinsPrevReg[i] && !wakePins[i])
                : (!pinsPrevReg[i] && wakePins[i]));     // see R17
            wakePendNext[i] = edgeEvt[i] ? 1'b1          // see R18
                : (wakePendClear[i] ? 1'b0 : wakePendingReg[i]);
        end
    end

    // Group request and wakeup decision from low-power modes.
    always_comb begin
        wakeActive   = wakeCfg.groupEn &&
                       (|(wakePendingReg & wakeCfg.enable)); // see R15, R16
        wakeupNext   = lowPowerMode && (|(edgeEvt & wakeCfg.enable));
        wakeServNext = wakeServiceReg;
        if (wakeupNext) begin
            wakeServNext = wakeCfg.groupEn && globalIrqEnable; // see R20
        end
    end

    // Wakeup registers.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pinsPrevReg    <= '0;
            primedReg      <= 1'b0;
            wakePendingReg <= '0;
            wakeupReg      <= 1'b0;
            wakeServiceReg <= 1'b0;
        end else begin
            pinsPrevReg    <= wakePins;
            primedReg      <= 1'b1;
            wakePendingReg <= wakePendNext;
            wakeupReg      <= wakeupNext;
            wakeServiceReg <= wakeServNext;
        end
    end

    // Maskable request and vector arbitration. The global enable is only
    // read here, never changed, so a trap leaves it as software set it.
    always_comb begin
        inIsrNext = inIsrReg;
        if (seqEvt.irqAck) begin
            inIsrNext = 1'b1;
        end else if (seqEvt.retIrq) begin
            inIsrNext = 1'b0;
        end
        irqReqNext = globalIrqEnable && !trapPendNext &&   // see R10, R11
                     !inIsrNext &&                         // see R14
                     (wakeActive || extIrqReq);            // see R19
        vectorNext = vectorLowReg;
        if (seqEvt.vector_dispatch_instr) begin
            if (trapPendingReg) begin
                vectorNext = taeil_pkg::VEC_TRAP;          // see R13, R10
            end else if (globalIrqEnable && extIrqReq) begin
                vectorNext = extIrqVec;
            end else if (globalIrqEnable && wakeActive) begin
                vectorNext = taeil_pkg::VEC_WAKE;          // see R15
            end else begin
                vectorNext = taeil_pkg::VEC_DEFAULT;       // see R22
            end
        end
    end

    // Request registers.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            inIsrReg     <= 1'b0;
            irqReqReg    <= 1'b0;
            vectorLowReg <= taeil_pkg::VEC_DEFAULT;
        end else begin
            inIsrReg     <= inIsrNext;
            irqReqReg    <= irqReqNext;
            vectorLowReg <= vectorNext;
        end
    end

    // Checks on the logic above.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    AST_TRAP_SET: assert property ( // see R3
        trapLoad |=> trapPendingReg && trapTakeReg)
        else $error("Trap opcode did not set pending and take.");

    AST_TRAP_KEEP: assert property ( // see R4
        trapPendingReg && !seqEvt.clearTrap |=> trapPendingReg)
        else $error("Trap pending dropped without clear.");

    AST_TRAP_CLEAR: assert property ( // see R4
        seqEvt.clearTrap && !trapLoad |=> !trapPendingReg)
        else $error("Clear instruction left trap pending set.");

    AST_TRAP_BLOCK: assert property ( // see R11
        trapPendingReg |-> !irqReqReg)
        else $error("Maskable request raised during trap.");

    AST_RET_ADDR: assert property ( // see R12
        trapLoad |=> trapReturnAddrReg == $past(seqEvt.instrAddr))
        else $error("Trap return address is not the trap address.");

    AST_ROM_ZERO: assert property ( // see R6
        !progDefined |=> progDataReg == taeil_pkg::UNDEF_ROM_DATA)
        else $error("Undefined program memory did not read zero.");

    AST_RAM_ONES: assert property ( // see R9
        ramUndef |=> ramDataReg == taeil_pkg::UNDEF_RAM_DATA)
        else $error("Undefined RAM did not read ones.");

    AST_UNDERFLOW: assert property ( // see R7
        underflow |=> pcForceReg &&
                      pcForceAddrReg == taeil_pkg::PC_UNDERFLOW)
        else $error("Stack underflow did not force the PC.");

    AST_EDGE_LATCH: assert property ( // see R18
        |edgeEvt |=> (wakePendingReg & $past(edgeEvt)) == $past(edgeEvt))
        else $error("Detected edge was not latched as pending.");

    AST_GIE_GATE: assert property ( // see R19
        !globalIrqEnable |=> !irqReqReg)
        else $error("Request raised with global enable clear.");

    AST_VIS_DEFAULT: assert property ( // see R22
        seqEvt.vector_dispatch_instr && !trapPendingReg && !extIrqReq && !wakeActive
        |=> vectorLowReg == taeil_pkg::VEC_DEFAULT)
        else $error("Idle dispatch did not pick the default vector.");

    AST_NO_PREEMPT: assert property ( // see R14
        inIsrReg && !seqEvt.retIrq |=> !irqReqReg)
        else $error("Maskable request raised inside a routine.");

    // Nesting, acknowledge, dispatch, wakeup and stack checks, one rule each.
    AST_TRAP_NEST: assert property ( // see R21
        trapLoad && seqEvt.clearTrap |=> trapPendingReg)
        else $error("Nested trap with clear dropped the pending flag.");

    AST_TAKE_PULSE: assert property ( // see R13
        trapTakeReg |-> $past(trapLoad))
        else $error("Trap take raised without a trap load.");

    AST_VIS_TRAP: assert property ( // see R13
        seqEvt.vector_dispatch_instr && trapPendingReg
        |=> vectorLowReg == taeil_pkg::VEC_TRAP)
        else $error("Dispatch with trap pending missed the trap vector.");

    AST_VIS_WAKE: assert property ( // see R15
        seqEvt.vector_dispatch_instr && !trapPendingReg && !extIrqReq &&
        globalIrqEnable && wakeActive
        |=> vectorLowReg == taeil_pkg::VEC_WAKE)
        else $error("Wakeup dispatch missed the shared wakeup vector.");

    AST_WAKE_GATE: assert property ( // see R19
        !wakeCfg.groupEn && !extIrqReq |=> !irqReqReg)
        else $error("Request raised with the wakeup group disabled.");

    AST_WAKE_SERVICE: assert property ( // see R20
        wakeupNext
        |=> wakeServiceReg == $past(wakeCfg.groupEn && globalIrqEnable))
        else $error("Wakeup service choice does not follow the enables.");

    AST_SP_PUSH: assert property ( // see R8
        seqEvt.push && !seqEvt.pop
        |=> stackPtrReg == $past(stackPtrReg) - 8'h01)
        else $error("Push did not move the stack pointer down.");

    AST_SP_POP: assert property ( // see R8
        seqEvt.pop && !seqEvt.push
        |=> stackPtrReg == $past(stackPtrReg) + 8'h01)
        else $error("Pop did not move the stack pointer up.");

    COV_TRAP_CLEAR: cover property (trapLoad ##[1:8] seqEvt.clearTrap);
    COV_WAKE_REQ: cover property (wakeActive && irqReqReg);
    COV_UNDERFLOW: cover property (underflow);
    COV_WAKEUP: cover property (wakeupReg && wakeServiceReg);

endmodule // taeil_trap_edge_irq

/* File: verification/taeil_seq_model.sv */
// Behavioural model of the instruction sequencer that feeds the trap logic.
// Assumes callers enter its tasks just after a rising clock edge.
module taeil_seq_model (
    input  wire logic                 core_clk,
    output taeil_pkg::taeil_seq_evt_t seqEvt
);
    timeunit 1ns;
    timeprecision 100ps;

    // The sequencer starts idle, with no event raised.
    initial seqEvt = '0;

    // Ends an event cycle. The release lands on the sampling edge itself,
    // so a following event is one assignment in a later time step. Released
    // opcode and address show the inverse of their last value and the event
    // bits clear, so a design that samples them late cannot see a stale match.
    task automatic endCycle(input taeil_pkg::taeil_seq_evt_t held);
        @(posedge core_clk);
        seqEvt <= {1'b0, ~held.opcode, ~held.instrAddr, 6'h00};
        #1;
    endtask

    // Loads one opcode, optionally with a clear-pending in the same cycle.
    task automatic ld(input logic [7:0] op, input logic [14:0] addr,
                      input logic clr);
        seqEvt = {1'b1, op, addr, clr, 5'h00};
        endCycle(seqEvt);
    endtask

    // Raises {clear, dispatch, ack, return, push, pop} for one cycle.
    task automatic ev(input logic [5:0] m);
        seqEvt = {1'b0, seqEvt.opcode, seqEvt.instrAddr, m};
        endCycle(seqEvt);
    endtask
endmodule // taeil_seq_model

/* File: verification/trap_and_edge_interrupt_logic_tb.sv */
// Self-checking bench for the trap and wakeup edge interrupt logic.
// Assumes the sequencer model above; expectations are stamped per cycle.
module trap_and_edge_interrupt_logic_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // Event masks for the sequencer model.
    localparam logic [5:0] CLR = 6'h20, VECTOR_DISPATCH_INSTR = 6'h10, ACK = 6'h08;
    localparam logic [5:0] RET = 6'h04, PSH = 6'h02, POP = 6'h01;

    // One noted result: the cycle it is due, which output, its value.
    typedef struct { int cyc; int sel; logic [14:0] val; } taeil_exp_t;

    logic core_clk, resetn, global_irq_enable, extReq, lpm, progDef;
    logic [7:0] extVec, pins, pendClr, progRaw, ramAddr, ramRaw, es, en, d;
    logic trapTake, trapPend, irqReq, pcForce, wakeup, wakeSvc;
    logic [14:0] retAddr, pcAddr;
    logic [7:0] vecLow, progData, ramData, sp, wakePend;
    taeil_pkg::taeil_seq_evt_t seqEvt;
    taeil_pkg::taeil_wake_cfg_t wakeCfg;
    taeil_exp_t expQ[$];        // Results still waiting for their cycle.
    int cycNow, nErrors, numChecks;

    taeil_seq_model seqModel (.core_clk(core_clk), .seqEvt(seqEvt));

    taeil_trap_edge_irq DUT (
        .core_clk(core_clk), .resetn(resetn), .seqEvt(seqEvt),
        .wakeCfg(wakeCfg), .globalIrqEnable(global_irq_enable), .extIrqReq(extReq),
        .extIrqVec(extVec), .lowPowerMode(lpm), .wakePins(pins),
        .wakePendClear(pendClr), .progDefined(progDef),
        .progRawData(progRaw), .ramAddr(ramAddr), .ramRawData(ramRaw),
        .trapTakeReg(trapTake), .trapReturnAddrReg(retAddr),
        .trapPendingReg(trapPend), .irqReqReg(irqReq),
        .vectorLowReg(vecLow), .progDataReg(progData),
        .ramDataReg(ramData), .stackPtrReg(sp), .pcForceReg(pcForce),
        .pcForceAddrReg(pcAddr), .wakePendingReg(wakePend),
        .wakeupReg(wakeup), .wakeServiceReg(wakeSvc));

    // A 250 MHz clock; the cycle counter names each rising edge.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cycNow <= cycNow + 1;

    // Selects an output by number, widened to the common compare width.
    function automatic logic [14:0] outSel(input int s);
        case (s)
            0: return {14'h0000, trapTake};
            1: return retAddr;
            2: return {14'h0000, trapPend};
            3: return {14'h0000, irqReq};
            4: return {7'h00, vecLow};
            5: return {7'h00, progData};
            6: return {7'h00, ramData};
            7: return {7'h00, sp};
            8: return {14'h0000, pcForce};
            9: return pcAddr;
            10: return {7'h00, wakePend};
            11: return {14'h0000, wakeup};
            default: return {14'h0000, wakeSvc};
        endcase
    endfunction

    // Compares one value; four-state equality keeps unknowns from passing.
    task automatic chk(input logic [14:0] seen, input logic [14:0] want);
        numChecks++;
        if (seen !== want) begin
            nErrors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask

    // Notes a result due dly edges after the current one.
    task automatic ex(input int s, input logic [14:0] v, input int dly);
        expQ.push_back('{cycNow + dly, s, v});
    endtask

    // Waits one cycle, leaving the bench just after the rising edge.
    task automatic cyc();
        @(posedge core_clk);
        #1;
    endtask

    // At the falling edge, outputs have settled: every note due now is compared.
    always @(negedge core_clk) begin
        for (int i = expQ.size() - 1; i >= 0; i--) begin
            if (expQ[i].cyc == cycNow) begin
                chk(outSel(expQ[i].sel), expQ[i].val);
                expQ.delete(i);
            end
        end
    end

    // Prints the verdict and ends the run.
    task automatic conclude();
        // A note never reached counts against the run.
        if (expQ.size() != 0) nErrors++;
        if (nErrors == 0 && numChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // A hang counts as a mismatch; the tests need well under 2000 cycles.
    initial begin
        #8000;
        nErrors++;
        conclude();
    end

    initial begin
        void'($urandom(98));
        {cycNow, nErrors, numChecks} = '0;
        {resetn, global_irq_enable, extReq, lpm, progDef} = 5'h00;
        {extVec, pins, pendClr, progRaw, ramAddr, ramRaw} = '0;
        wakeCfg = '0;
        repeat (5) begin
            cyc();
            ex(7, 15'h002f, 0);
            ex(4, 15'h00e0, 0);
            ex(2, 15'h0000, 0);
        end
        resetn = 1'b1;
        // Program and RAM reads, undefined places mixed with real ones.
        for (int i = 0; i < 16; i++) begin
            d = 8'($urandom);
            progDef = i[0];
            progRaw = d;
            ramRaw = d;
            ramAddr = i[1] ? {4'h3, d[3:0]} : 8'($urandom);
            ex(5, progDef ? {7'h00, d} : 15'h0000, 1);
            ex(6, (ramAddr >= 8'h30 && ramAddr <= 8'h3f) ? 15'h00ff
                  : {7'h00, d}, 1);
            cyc();
        end
        // Traps against a pending maskable request.
        {global_irq_enable, extReq, extVec} = {2'b11, 8'hf4};
        ex(0, 15'h0000, 1);
        ex(3, 15'h0001, 1);
        seqModel.ld(8'h5a, 15'h1234, 1'b0);
        ex(0, 15'h0001, 1);
        ex(1, 15'h2a5b, 1);
        ex(2, 15'h0001, 1);
        ex(3, 15'h0000, 1);
        seqModel.ld(8'h00, 15'h2a5b, 1'b0);
        ex(0, 15'h0001, 1);
        ex(2, 15'h0001, 1);
        seqModel.ld(8'h00, 15'h0777, 1'b1);
        ex(4, 15'h00fe, 1);
        seqModel.ev(VECTOR_DISPATCH_INSTR);
        ex(2, 15'h0000, 1);
        ex(3, 15'h0001, 2);
        seqModel.ev(CLR);
        cyc();
        ex(4, 15'h00f4, 1);
        seqModel.ev(VECTOR_DISPATCH_INSTR);
        ex(3, 15'h0000, 1);
        seqModel.ev(ACK);
        ex(0, 15'h0001, 1);
        seqModel.ld(8'h00, 15'h0100, 1'b0);
        seqModel.ev(CLR);
        ex(3, 15'h0001, 1);
        seqModel.ev(RET);
        extReq = 1'b0;
        ex(4, 15'h00e0, 1);
        seqModel.ev(VECTOR_DISPATCH_INSTR);
        // Stack moves, then an underflow past the limit.
        ex(7, 15'h002e, 1);
        seqModel.ev(PSH);
        ex(7, 15'h002f, 1);
        ex(8, 15'h0000, 1);
        seqModel.ev(POP);
        ex(7, 15'h002f, 1);
        seqModel.ev(PSH | POP);
        for (int i = 0; i < 64; i++) begin
            ex(7, 15'h0030 + 15'(i), 1);
            seqModel.ev(POP);
        end
        ex(8, 15'h0001, 1);
        ex(9, 15'h7fff, 1);
        seqModel.ev(POP);
        // A second reset while a trap is pending.
        seqModel.ld(8'h00, 15'h0042, 1'b0);
        resetn = 1'b0;
        ex(2, 15'h0000, 0);
        ex(7, 15'h002f, 0);
        cyc();
        resetn = 1'b1;
        // Wakeup port: random edge choice and enables over all pins.
        es = 8'($urandom);
        en = 8'($urandom);
        wakeCfg = '{1'b1, es, en};
        pins = es;
        cyc();
        pendClr = 8'hff;
        lpm = 1'b1;
        cyc();
        pendClr = 8'h00;
        for (int i = 0; i < 8; i++) begin
            pins[i] = ~es[i];
            ex(10, 15'(8'h01 << i), 1);
            ex(11, 15'(en[i]), 1);
            if (en[i]) ex(12, 15'h0001, 1);
            ex(3, 15'(en[i]), 2);
            cyc();
            pins[i] = es[i];
            ex(10, 15'(8'h01 << i), 1);
            ex(4, en[i] ? 15'h00e2 : 15'h00e0, 1);
            seqModel.ev(VECTOR_DISPATCH_INSTR);
            pendClr[i] = 1'b1;
            ex(10, 15'h0000, 1);
            cyc();
            pendClr[i] = 1'b0;
        end
        // With the group disabled the wakeup resumes without service.
        wakeCfg = '{1'b0, 8'h00, 8'hff};
        pins = 8'h00;
        cyc();
        pins = 8'h01;
        ex(11, 15'h0001, 1);
        ex(12, 15'h0000, 1);
        ex(3, 15'h0000, 2);
        cyc();
        // Outside low-power mode an enabled edge latches but does not wake.
        lpm = 1'b0;
        pins = 8'h03;
        ex(11, 15'h0000, 1);
        ex(10, 15'h0003, 1);
        repeat (3) cyc();
        conclude();
    end
endmodule // trap_and_edge_interrupt_logic_tb
